/* design/fwc_pkg.sv */
// fwc_pkg: register map, field positions, reset values and timing figures of the warm-up counter.
// assumes a 32-bit AHB-Lite register bus, word-aligned registers, one 250 MHz clock.
package fwc_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_UPPER_CTRL = 8'h00;
	localparam logic [7:0] ADDR_LOWER_CTRL = 8'h04;
	localparam logic [7:0] ADDR_COMPARE = 8'h08;
	localparam logic [7:0] ADDR_COUNT = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_MASK = 8'h14;
	localparam logic [7:0] ADDR_SYS_CLK = 8'h18;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_MSB = 7;

	// upper_timer_ctrl fields, with lower control reset and mode values
	localparam int UPPER_RUN_BIT = 3;
	localparam logic [7:0] UPPER_CTRL_RST = 8'h00;
	localparam logic [7:0] LOWER_CTRL_RST = 8'h00;
	localparam logic [7:0] WARMUP_MODE_VAL = 8'h05;
	localparam logic [7:0] CASCADE_MODE_VAL = 8'h63;

	// compare register pair; low byte takes no part in matching
	localparam logic [15:0] COMPARE_RST = 16'h0000;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;

	// status / mask layout
	localparam int MATCH_BIT = 0;
	localparam logic [0:0] STATUS_RST = 1'h0;
	localparam logic [0:0] MASK_RST = 1'h0;

	// system_clock_ctrl fields
	localparam int FAST_OSC_EN_BIT = 7;
	localparam int SLOW_OSC_EN_BIT = 6;
	localparam int CLK_SEL_BIT = 5;
	localparam logic [7:0] SYS_CLK_RST = 8'h40;

	// warm-up figures, in nanoseconds and in fast-oscillator ticks
	localparam int FAST_CLOCK_KHZ = 16000;
	localparam int MIN_WARMUP_NS = 16000;
	localparam int MAX_WARMUP_NS = 4080000;
	localparam logic [15:0] COMPARE_MIN = 16'h0100;
	localparam logic [15:0] COMPARE_MAX = 16'hFF00;
	// scaled in two steps: the plain product overflows a 32-bit int
	localparam int NS_PER_US = 1000;
	localparam int MIN_WARMUP_TICKS = (MIN_WARMUP_NS / NS_PER_US) * FAST_CLOCK_KHZ / NS_PER_US;
	localparam int MAX_WARMUP_TICKS = (MAX_WARMUP_NS / NS_PER_US) * FAST_CLOCK_KHZ / NS_PER_US;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

/* design/fwc_sync.sv */
// fwc_sync: two-flop synchroniser for a level arriving from another clock.
// assumes the input may change at any time relative to clock_i.
`timescale 1ns/1ns
module fwc_sync
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic async_i,
	output logic sync_o
);
	logic meta_reg;
	logic meta_next;
	logic sync_reg;
	logic sync_next;

	always_comb
	begin
		meta_next = meta_reg;
		sync_next = sync_reg;
		if (ce_i)
		begin
			meta_next = async_i;
			sync_next = meta_reg;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_o = sync_reg;
endmodule

/* design/fwc_warmup.sv */
// fwc_warmup: cascaded 16-bit warm-up counter with AHB-Lite registers and a match interrupt.
// assumes osc_tick_i toggles at the oscillator being warmed, far slower than clock_i.
//
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
// What this block does
// - counter counts up once the upper run bit is written one
// - on match with compare value, counter clears and match flag sets; interrupt rises only if mask bit is set
// - compare 0100H gives shortest interval, 16 us of fast clock
// - compare FF00H gives longest interval, 4.08 ms of fast clock
// - matching uses only the upper eight compare bits
module fwc_warmup
	import fwc_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic osc_tick_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic upper_timer_match_irq_o,
	output logic fast_osc_en_o,
	output logic slow_osc_en_o,
	output logic sys_clk_sel_o
);
	logic tick_sync;
	logic tick_prev_reg;
	logic tick_prev_next;
	logic tick_rise;

	logic [7:0] upper_ctrl_reg;
	logic [7:0] upper_ctrl_next;
	logic [7:0] lower_ctrl_reg;
	logic [7:0] lower_ctrl_next;
	logic [15:0] compare_reg;
	logic [15:0] compare_next;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [0:0] status_reg;
	logic [0:0] status_next;
	logic [0:0] mask_reg;
	logic [0:0] mask_next;
	logic [7:0] sys_clk_reg;
	logic [7:0] sys_clk_next;
	logic irq_reg;
	logic irq_next;

	logic wr_pend_reg;
	logic wr_pend_next;
	logic [ADDR_MSB:ADDR_LSB] wr_addr_reg;
	logic [ADDR_MSB:ADDR_LSB] wr_addr_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	logic run;
	logic [15:0] count_inc;
	logic match;
	logic access;
	logic [ADDR_MSB:ADDR_LSB] a_idx;

	// oscillator tick crosses from the pin domain
	fwc_sync u_tick_sync
	(
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.async_i(osc_tick_i),
		.sync_o(tick_sync)
	);

	assign tick_rise = tick_sync & ~tick_prev_reg;
	assign run = upper_ctrl_reg[UPPER_RUN_BIT];
	assign count_inc = count_reg + COUNT_ONE;
	assign match = run & tick_rise & (count_inc[15:8] == compare_reg[15:8]);
	assign access = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ | htrans_i == HTRANS_SEQ);
	assign a_idx = haddr_i[ADDR_MSB:ADDR_LSB];

	always_comb
	begin
		tick_prev_next = tick_sync;
		count_next = count_reg;
		// clear on match; interval equals compare high byte times 256 ticks
		if (!run)
		begin
			count_next = COUNT_RST;
		end
		else if (match)
		begin
			count_next = COUNT_RST;
		end
		else if (tick_rise)
		begin
			count_next = count_inc;
		end
	end

	// register bus: address phase captured, writes land in data phase
	always_comb
	begin
		wr_pend_next = access & hwrite_i;
		wr_addr_next = access ? a_idx : wr_addr_reg;
		rdata_next = ZERO_WORD;
		if (access & ~hwrite_i)
		begin
			unique case ({a_idx, 2'b00})
				ADDR_UPPER_CTRL: rdata_next[7:0] = upper_ctrl_reg;
				ADDR_LOWER_CTRL: rdata_next[7:0] = lower_ctrl_reg;
				ADDR_COMPARE: rdata_next[15:0] = compare_reg;
				ADDR_COUNT: rdata_next[15:0] = count_reg;
				ADDR_STATUS: rdata_next[MATCH_BIT] = status_reg[MATCH_BIT];
				ADDR_MASK: rdata_next[MATCH_BIT] = mask_reg[MATCH_BIT];
				ADDR_SYS_CLK: rdata_next[7:0] = sys_clk_reg;
				default: rdata_next = ZERO_WORD;
			endcase
		end
		upper_ctrl_next = upper_ctrl_reg;
		lower_ctrl_next = lower_ctrl_reg;
		compare_next = compare_reg;
		mask_next = mask_reg;
		sys_clk_next = sys_clk_reg;
		status_next = status_reg;
		if (wr_pend_reg)
		begin
			unique case ({wr_addr_reg, 2'b00})
				// start and stop through run bit
				ADDR_UPPER_CTRL: upper_ctrl_next = hwdata_i[7:0];
				ADDR_LOWER_CTRL: lower_ctrl_next = hwdata_i[7:0];
				ADDR_COMPARE: compare_next = hwdata_i[15:0];
				ADDR_MASK: mask_next = hwdata_i[MATCH_BIT +: 1];
				ADDR_STATUS: status_next = status_reg & ~hwdata_i[MATCH_BIT +: 1];
				ADDR_SYS_CLK: sys_clk_next = hwdata_i[7:0];
				default: status_next = status_reg;
			endcase
		end
		// match sets flag, winning over a same-cycle clear
		if (match)
		begin
			status_next[MATCH_BIT] = 1'b1;
		end
		irq_next = |(status_next & mask_next);
	end

	// whole block freezes while ce_i is low, bus included
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tick_prev_reg <= 1'b0;
			upper_ctrl_reg <= UPPER_CTRL_RST;
			lower_ctrl_reg <= LOWER_CTRL_RST;
			compare_reg <= COMPARE_RST;
			count_reg <= COUNT_RST;
			status_reg <= STATUS_RST;
			mask_reg <= MASK_RST;
			sys_clk_reg <= SYS_CLK_RST;
			irq_reg <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
			rdata_reg <= ZERO_WORD;
		end
		else if (ce_i)
		begin
			tick_prev_reg <= tick_prev_next;
			upper_ctrl_reg <= upper_ctrl_next;
			lower_ctrl_reg <= lower_ctrl_next;
			compare_reg <= compare_next;
			count_reg <= count_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			sys_clk_reg <= sys_clk_next;
			irq_reg <= irq_next;
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			rdata_reg <= rdata_next;
		end
	end

	assign hrdata_o = rdata_reg;
	// zero-wait slave, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign upper_timer_match_irq_o = irq_reg;
	// clock select and oscillator enables are plain register bits
	assign fast_osc_en_o = sys_clk_reg[FAST_OSC_EN_BIT];
	assign slow_osc_en_o = sys_clk_reg[SLOW_OSC_EN_BIT];
	assign sys_clk_sel_o = sys_clk_reg[CLK_SEL_BIT];

	// assertion helper: a match seen, its next tick not yet arrived
	logic rerun_wait_reg;
	logic rerun_wait_next;

	always_comb
	begin
		rerun_wait_next = rerun_wait_reg;
		if (ce_i)
		begin
			rerun_wait_next = match | (rerun_wait_reg & ~tick_rise);
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rerun_wait_reg <= 1'b0;
		end
		else
		begin
			rerun_wait_reg <= rerun_wait_next;
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	a_match_clears: assert property (ce_i && match |=> count_reg == COUNT_RST)
		else $error("count not cleared after match");
	a_match_flags: assert property (ce_i && match |=> status_reg[MATCH_BIT])
		else $error("match flag not set");
	a_count_step: assert property (ce_i && run && tick_rise && !match |=> count_reg == $past(count_reg) + COUNT_ONE)
		else $error("counter did not step");
	a_count_hold: assert property (ce_i && run && !tick_rise |=> $stable(count_reg))
		else $error("counter moved without tick");
	a_stop_zero: assert property (ce_i && !run |=> count_reg == COUNT_RST)
		else $error("stopped counter not zero");
	a_high_byte_only: assert property (ce_i && run && tick_rise && count_inc == {compare_reg[15:8], COUNT_RST[7:0]}
		|=> count_reg == COUNT_RST)
		else $error("match not on high byte");
	a_rerun_after: assert property (ce_i && rerun_wait_reg && run && tick_rise && !match |=> count_reg == COUNT_ONE)
		else $error("count not restarted from zero");
	a_min_interval: assert property (ce_i && match && compare_reg[15:8] == COMPARE_MIN[15:8]
		|-> count_reg == 16'(MIN_WARMUP_TICKS) - COUNT_ONE)
		else $error("short interval wrong");
	a_irq_follows: assert property (upper_timer_match_irq_o == |(status_reg & mask_reg))
		else $error("irq does not track status and mask");
	a_freeze_state: assert property (!ce_i |=> $stable(count_reg) && $stable(status_reg))
		else $error("state moved while frozen");

	c_match: cover property (ce_i && match);
	c_irq_raise: cover property (!upper_timer_match_irq_o ##1 upper_timer_match_irq_o);
	c_flag_cleared: cover property (status_reg[MATCH_BIT] ##1 !status_reg[MATCH_BIT]);
endmodule

/* tb/tb.sv */
// tb: self-checking bench for the warm-up counter, its registers and match interrupt.
// assumes fwc_warmup answers every AHB-Lite transfer with zero wait states.
`timescale 1ns/1ns
module tb;
	import fwc_pkg::*;
	logic clock_i = 0, rst_n_i = 0, osc_tick_i = 0, hsel_i = 0, hwrite_i = 0, ce_i = 1;
	logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rv;
	logic [1:0] htrans_i = 0;
	logic hreadyout_o, hresp_o, irq_o, fast_o, slow_o, sel_o;
	int fail_count = 0, n_checks = 0, cycles = 0, cnt = 0, cmp = 0, st = 0, mk = 0, run = 0, frz = 0, b;
	fwc_warmup dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .osc_tick_i(osc_tick_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.upper_timer_match_irq_o(irq_o), .fast_osc_en_o(fast_o), .slow_osc_en_o(slow_o), .sys_clk_sel_o(sel_o));
	initial
	begin
		forever #2 clock_i = ~clock_i;
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// hang is cut short by the cycle ceiling, not here
	task automatic bus(logic we, logic [7:0] a, logic [31:0] d);
		@(posedge clock_i);
		hsel_i <= 1'b1;
		haddr_i <= {24'h0, a};
		htrans_i <= HTRANS_NONSEQ;
		hwrite_i <= we;
		@(posedge clock_i);
		while (hreadyout_o !== 1'b1)
			@(posedge clock_i);
		htrans_i <= 2'h0;
		hsel_i <= 1'b0;
		hwdata_i <= we ? d : 32'h0;
		@(posedge clock_i);
		while (hreadyout_o !== 1'b1)
			@(posedge clock_i);
		rv = hrdata_o;
		chk("hresp", 32'h0, {31'h0, hresp_o});
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(string name, logic [7:0] a, logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(name, exp, rv);
	endtask
	// pins settle on the edge a write lands; checked two edges later
	task automatic pins(logic [2:0] clk_bits);
		repeat (2) @(posedge clock_i);
		chk("pins", {28'h0, 1'(st & mk), clk_bits}, {28'h0, irq_o, fast_o, slow_o, sel_o});
	endtask
	// ticks stay 3 clocks high and 3 low, above the 2-clock minimum
	task automatic ticks(int n);
		repeat (n)
		begin
			osc_tick_i <= 1'b1;
			repeat (3) @(posedge clock_i);
			osc_tick_i <= 1'b0;
			repeat (3) @(posedge clock_i);
			cnt = frz ? cnt : run ? cnt + 1 : 0;
			if (!frz && run && cnt == (cmp >> 8) * 256)
			begin
				cnt = 0;
				st = 1;
			end
		end
		repeat (6) @(posedge clock_i);
	endtask
	always @(posedge clock_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			close_out();
		end
	end
	initial
	begin
		void'($urandom(71677));
		repeat (5) @(posedge clock_i);
		rst_n_i <= 1'b1;
		pins(3'b010);
		rd("sys_clk", ADDR_SYS_CLK, 32'h40);
		rd("compare", ADDR_COMPARE, 32'h0);
		rd("status", ADDR_STATUS, 32'h0);
		wr(8'h1C, 32'hFFFF_FFFF);
		rd("unmapped", 8'h1C, 32'h0);
		$display("test reset done");
		repeat (4)
		begin
			b = $urandom & 32'hFF;
			wr(ADDR_SYS_CLK, b);
			rd("sys_clk", ADDR_SYS_CLK, b);
			pins(b[7:5]);
		end
		$display("test clock control done");
		wr(ADDR_SYS_CLK, 32'hE0);
		wr(ADDR_LOWER_CTRL, 32'h63);
		rd("lower_ctrl", ADDR_LOWER_CTRL, 32'h63);
		cmp = 32'h0100 | ($urandom & 32'hFF);
		wr(ADDR_COMPARE, cmp);
		rd("compare", ADDR_COMPARE, cmp);
		mk = 1;
		wr(ADDR_MASK, 1);
		wr(ADDR_UPPER_CTRL, 32'h05);
		run = 1;
		wr(ADDR_UPPER_CTRL, 32'h0D);
		ticks(255);
		rd("count", ADDR_COUNT, cnt);
		pins(3'b111);
		ticks(1);
		rd("count", ADDR_COUNT, cnt);
		rd("status", ADDR_STATUS, st);
		pins(3'b111);
		ticks(5);
		rd("count", ADDR_COUNT, cnt);
		// ticks while frozen are lost, count must not move
		frz = 1;
		ce_i <= 1'b0;
		ticks(4);
		ce_i <= 1'b1;
		frz = 0;
		rd("count", ADDR_COUNT, cnt);
		$display("test freeze done");
		run = 0;
		wr(ADDR_UPPER_CTRL, 32'h05);
		wr(ADDR_SYS_CLK, 32'hC0);
		pins(3'b110);
		wr(ADDR_SYS_CLK, 32'h80);
		ticks(3);
		rd("count", ADDR_COUNT, 0);
		st = 0;
		wr(ADDR_STATUS, 1);
		pins(3'b100);
		$display("test warm-up done");
		mk = 0;
		wr(ADDR_MASK, 0);
		cmp = ((($urandom % 3) + 1) << 8) | ($urandom & 32'hFF);
		wr(ADDR_COMPARE, cmp);
		run = 1;
		wr(ADDR_UPPER_CTRL, 32'h0D);
		ticks((cmp >> 8) * 256);
		rd("status", ADDR_STATUS, st);
		pins(3'b100);
		mk = 1;
		wr(ADDR_MASK, 1);
		pins(3'b100);
		st = 0;
		wr(ADDR_STATUS, 1);
		pins(3'b100);
		$display("test mask done");
		close_out();
	end
endmodule
